/* File: rtl/isd_irq_consts.vh */
// Constants for the interrupt aggregator: register map, bit layout, reset values, timing counts.
// Assumes inclusion by isd_bchan_rx and isd_irq_agg; isd_sticky does not include it; definitions only.
// Contract
// - One active-low interrupt while unmasked event pending
// - Top status bits 5-0 point to sub-registers
// - Aux pin events land directly in bits 6,7
// - Two summary bits per D and B channel
// - Host reads top status, then pointed sub-registers
// - Interrupt holds until every source cleared: sub-registers by read, aux bits 6,7 by write one to top
// - Top mask bit suppresses matching interrupt indication
// - B-channel status bits masked per channel mask
// - Pool full after 64 bytes of open frame
// - Frame start only while its enable set
// - Frame start after address/opening flag, two bytes later
// - Header, address, status nibble valid at frame start
// - Aux inputs selectable edge or level trigger
// - Reading D extended clears it and summary
// - Masked bits hidden on read, kept pending; top status still reads bits masked by the top mask
`ifndef ISD_IRQ_CONSTS_VH
`define ISD_IRQ_CONSTS_VH

`define ISD_AW 5
`define ISD_DW 8
// Global registers
`define ISD_A_TOP 5'h00
`define ISD_A_TMASK 5'h01
`define ISD_A_AUXCFG 5'h02
`define ISD_A_DST 5'h03
`define ISD_A_DMASK 5'h04
`define ISD_A_DEXT 5'h05
// Channel windows, selected by address bits 4-3
`define ISD_SEL_A 2'h1
`define ISD_SEL_B 2'h2
`define ISD_O_ST 3'h0
`define ISD_O_MASK 3'h1
`define ISD_O_EXT 3'h2
`define ISD_O_CMD2 3'h3
`define ISD_O_HDR 3'h4
`define ISD_O_ADDR 3'h5
`define ISD_O_RSTAT 3'h6
// Top status bit positions
`define ISD_T_EXB 0
`define ISD_T_ICB 1
`define ISD_T_EXA 2
`define ISD_T_ICA 3
`define ISD_T_EXD 4
`define ISD_T_IDC 5
`define ISD_T_AUX_IN_SIX 6
`define ISD_T_AUX_IN_SEVEN 7
// B-channel status and extended layouts
`define ISD_BST_RME 7
`define ISD_BST_RPF 6
`define ISD_BEX_RFO 7
`define ISD_BEX_RFS 6
`define ISD_CMD2_RIE 0
// Aux config: bit set selects edge trigger
`define ISD_CFG_EL6 0
`define ISD_CFG_EL7 1
`define ISD_REG_RST 8'h00
`define ISD_POOL_BYTES 64
`define ISD_RFS_DELAY 2

`endif

/* File: rtl/isd_sticky.v */
// Sticky event register with per-bit mask and read-clear of the visible bits.
// Assumes set pulses and read strobe on the same clock as the host port.
`timescale 1ns/1ps
module isd_sticky #(
	parameter W = 8
) (
	input wire clk,
	input wire reset,
	input wire [W-1:0] set,
	input wire [W-1:0] mask,
	input wire rd_clr,
	output wire [W-1:0] view,
	output wire pend
);
	reg [W-1:0] st_q;
	wire [W-1:0] st_d;

	// Masked bits survive the read; a new event wins over the clear
	assign st_d = (rd_clr ? (st_q & mask) : st_q) | set;
	assign view = st_q & ~mask;
	assign pend = |view;

	always @(posedge clk) begin
		if (reset) begin
			st_q <= {W{1'b0}};
		end else begin
			st_q <= st_d;
		end
	end
endmodule // isd_sticky

/* File: rtl/isd_bchan_rx.v */
// B-channel receive event generator: pool full, message end, overflow, frame start.
// Assumes one-cycle pulses from the receive HDLC framer on the same clock.
`timescale 1ns/1ps
`include "isd_irq_consts.vh"
module isd_bchan_rx #(
	parameter POOL = `ISD_POOL_BYTES,
	parameter DLY = `ISD_RFS_DELAY
) (
	input wire clk,
	input wire reset,
	input wire byte_stored,
	input wire frame_open,
	input wire addr_ok,
	input wire msg_done,
	input wire fifo_full,
	input wire transparent,
	input wire start_en,
	input wire [7:0] hdr_in,
	input wire [7:0] addr_in,
	input wire [3:0] rstat_in,
	output reg pool_full_q,
	output reg msg_end_q,
	output reg overflow_q,
	output reg frame_start_q,
	output reg [7:0] hdr_q,
	output reg [7:0] addr_q,
	output reg [3:0] rstat_q
);
	localparam CW = $clog2(POOL + 1);
	localparam DW = $clog2(DLY + 1);
	localparam [CW-1:0] POOL_LAST = POOL - 1;
	localparam [DW-1:0] DLY_N = DLY;

	reg [CW-1:0] cnt_q;
	reg [DW-1:0] dly_q;
	reg in_frame_q;
	reg armed_q;
	wire accept;
	wire trig;
	wire fire;

	assign accept = frame_open & ~fifo_full;
	assign trig = in_frame_q & (transparent ? 1'b0 : addr_ok);
	// Zero delay would need firing on the trigger itself; not supported
	assign fire = armed_q & byte_stored & (dly_q == DLY_N - 1'b1);

	always @(posedge clk) begin
		if (reset) begin
			cnt_q <= {CW{1'b0}};
			dly_q <= {DW{1'b0}};
			in_frame_q <= 1'b0;
			armed_q <= 1'b0;
			pool_full_q <= 1'b0;
			msg_end_q <= 1'b0;
			overflow_q <= 1'b0;
			frame_start_q <= 1'b0;
			hdr_q <= `ISD_REG_RST;
			addr_q <= `ISD_REG_RST;
			rstat_q <= 4'h0;
		end else begin
			pool_full_q <= 1'b0;
			msg_end_q <= 1'b0;
			overflow_q <= frame_open & fifo_full;
			frame_start_q <= fire & start_en;
			if (frame_open) begin
				// A lost frame gets no further events
				in_frame_q <= accept;
				cnt_q <= {CW{1'b0}};
				armed_q <= accept & transparent;
				dly_q <= {DW{1'b0}};
			end else begin
				if (msg_done & in_frame_q) begin
					msg_end_q <= 1'b1;
					in_frame_q <= 1'b0;
					cnt_q <= {CW{1'b0}};
					armed_q <= 1'b0;
				end else if (byte_stored & in_frame_q) begin
					if (cnt_q == POOL_LAST) begin
						pool_full_q <= 1'b1;
						cnt_q <= {CW{1'b0}};
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				if (trig) begin
					armed_q <= 1'b1;
					dly_q <= {DW{1'b0}};
				end else if (armed_q & byte_stored) begin
					dly_q <= dly_q + 1'b1;
					if (fire) begin
						armed_q <= 1'b0;
					end
				end
			end
			if (fire & start_en) begin
				hdr_q <= hdr_in;
				addr_q <= addr_in;
				rstat_q <= rstat_in;
			end
		end
	end
endmodule // isd_bchan_rx

/* File: rtl/isd_irq_agg.v */
// Interrupt aggregator: top status, masks, D and B channel event registers, aux pin inputs.
// Assumes a plain register port on clk and event pulses from the HDLC controllers on clk.
// Channel index 0 is channel A, index 1 is channel B.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "isd_irq_consts.vh"
module isd_irq_agg #(
	parameter POOL = `ISD_POOL_BYTES,
	parameter DLY = `ISD_RFS_DELAY
) (
	input wire clk,
	input wire reset,
	input wire [`ISD_AW-1:0] addr,
	input wire [`ISD_DW-1:0] wdata,
	input wire wr,
	input wire rd,
	output reg [`ISD_DW-1:0] rdata_q,
	output reg int_n_q,
	input wire aux_in_six_n,
	input wire aux_in_seven_n,
	input wire [7:0] dchan_status_evt,
	input wire [7:0] dchan_ext_evt,
	input wire [1:0] rx_byte_stored,
	input wire [1:0] rx_frame_open,
	input wire [1:0] rx_addr_ok,
	input wire [1:0] rx_msg_done,
	input wire [1:0] rx_fifo_full,
	input wire [1:0] rx_transparent,
	input wire [15:0] rx_hdr_in,
	input wire [15:0] rx_addr_in,
	input wire [7:0] rx_rstat_in,
	input wire [11:0] bchan_status_evt,
	input wire [11:0] bchan_ext_evt
);
	// Pin synchroniser: three stages, a change counts once stages two and three agree
	reg [1:0] s1_q;
	reg [1:0] s2_q;
	reg [1:0] s3_q;
	reg [1:0] pin_q;
	reg [1:0] pin_old_q;
	wire [1:0] pin_ok;
	wire [1:0] pin_fall;
	wire [1:0] pin_low;
	wire [1:0] edge_sel;
	wire [1:0] aux_set;

	// Software registers
	reg [7:0] tmask_q;
	reg [7:0] auxcfg_q;
	reg [7:0] dmask_q;
	reg [15:0] bmask_q;
	reg [1:0] rie_q;
	reg [1:0] aux_q;

	// Address decode
	wire [1:0] sel;
	wire [2:0] off;
	wire glob;
	wire ch_a;
	wire ch_b;
	wire rd_dst;
	wire rd_dext;
	wire [1:0] rd_bst;
	wire [1:0] rd_bext;
	wire wr_top;

	// Receive events per channel
	wire [1:0] rx_pool_full;
	wire [1:0] rx_message_end;
	wire [1:0] rx_frame_overflow;
	wire [1:0] rx_frame_start;
	wire [15:0] hdr;
	wire [15:0] adl;
	wire [7:0] rst4;

	// Sticky register bank, order matches top status bits 5-0
	wire [47:0] st_set;
	wire [47:0] st_mask;
	wire [5:0] st_clr;
	wire [47:0] st_view;
	wire [5:0] st_pend;
	wire [7:0] top;
	wire [7:0] b_st_set [0:1];
	wire [7:0] b_ex_set [0:1];
	reg [7:0] rd_d;
	genvar g;

	assign pin_ok = ~(s2_q ^ s3_q);
	assign pin_fall = pin_old_q & ~pin_q;
	assign pin_low = ~pin_q;
	assign edge_sel = {auxcfg_q[`ISD_CFG_EL7], auxcfg_q[`ISD_CFG_EL6]};
	// Level mode keeps setting while the pin is low, so the bit cannot be cleared until release
	assign aux_set = (edge_sel & pin_fall) | (~edge_sel & pin_low);

	always @(posedge clk) begin
		if (reset) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h3;
			pin_q <= 2'h3;
			pin_old_q <= 2'h3;
		end else begin
			s1_q <= {aux_in_seven_n, aux_in_six_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (pin_ok & s3_q) | (~pin_ok & pin_q);
			pin_old_q <= pin_q;
		end
	end

	assign sel = addr[4:3];
	assign off = addr[2:0];
	assign glob = (sel == 2'h0);
	assign ch_a = (sel == `ISD_SEL_A);
	assign ch_b = (sel == `ISD_SEL_B);
	assign rd_dst = rd & (addr == `ISD_A_DST);
	assign rd_dext = rd & (addr == `ISD_A_DEXT);
	assign rd_bst = {rd & ch_b & (off == `ISD_O_ST), rd & ch_a & (off == `ISD_O_ST)};
	assign rd_bext = {rd & ch_b & (off == `ISD_O_EXT), rd & ch_a & (off == `ISD_O_EXT)};
	assign wr_top = wr & (addr == `ISD_A_TOP);

	// Software registers; masks use 1 = suppressed
	always @(posedge clk) begin
		if (reset) begin
			tmask_q <= `ISD_REG_RST;
			auxcfg_q <= `ISD_REG_RST;
			dmask_q <= `ISD_REG_RST;
			bmask_q <= {2{`ISD_REG_RST}};
			rie_q <= 2'h0;
		end else if (wr) begin
			if (addr == `ISD_A_TMASK) begin
				tmask_q <= wdata;
			end
			if (addr == `ISD_A_AUXCFG) begin
				auxcfg_q <= wdata;
			end
			if (addr == `ISD_A_DMASK) begin
				dmask_q <= wdata;
			end
			if (ch_a & (off == `ISD_O_MASK)) begin
				bmask_q[7:0] <= wdata;
			end
			if (ch_b & (off == `ISD_O_MASK)) begin
				bmask_q[15:8] <= wdata;
			end
			if (ch_a & (off == `ISD_O_CMD2)) begin
				rie_q[0] <= wdata[`ISD_CMD2_RIE];
			end
			if (ch_b & (off == `ISD_O_CMD2)) begin
				rie_q[1] <= wdata[`ISD_CMD2_RIE];
			end
		end
	end

	// Aux bits have no sub-register: write one to clear, a new event wins
	always @(posedge clk) begin
		if (reset) begin
			aux_q <= 2'h0;
		end else if (wr_top) begin
			aux_q <= (aux_q & ~{wdata[`ISD_T_AUX_IN_SEVEN], wdata[`ISD_T_AUX_IN_SIX]}) | aux_set;
		end else begin
			aux_q <= aux_q | aux_set;
		end
	end

	generate
		for (g = 0; g < 2; g = g + 1) begin : g_rx
			isd_bchan_rx #(
				.POOL(POOL),
				.DLY(DLY)
			) u_rx (
				.clk(clk),
				.reset(reset),
				.byte_stored(rx_byte_stored[g]),
				.frame_open(rx_frame_open[g]),
				.addr_ok(rx_addr_ok[g]),
				.msg_done(rx_msg_done[g]),
				.fifo_full(rx_fifo_full[g]),
				.transparent(rx_transparent[g]),
				.start_en(rie_q[g]),
				.hdr_in(rx_hdr_in[8*g+7:8*g]),
				.addr_in(rx_addr_in[8*g+7:8*g]),
				.rstat_in(rx_rstat_in[4*g+3:4*g]),
				.pool_full_q(rx_pool_full[g]),
				.msg_end_q(rx_message_end[g]),
				.overflow_q(rx_frame_overflow[g]),
				.frame_start_q(rx_frame_start[g]),
				.hdr_q(hdr[8*g+7:8*g]),
				.addr_q(adl[8*g+7:8*g]),
				.rstat_q(rst4[4*g+3:4*g])
			);
			assign b_st_set[g] = {rx_message_end[g], rx_pool_full[g], bchan_status_evt[6*g+5:6*g]};
			assign b_ex_set[g] = {rx_frame_overflow[g], rx_frame_start[g], bchan_ext_evt[6*g+5:6*g]};
		end
	endgenerate

	// Bank index: 0 B ext, 1 B status, 2 A ext, 3 A status, 4 D ext, 5 D status
	assign st_set = {dchan_status_evt, dchan_ext_evt, b_st_set[0], b_ex_set[0], b_st_set[1], b_ex_set[1]};
	assign st_mask = {dmask_q, 8'h00, bmask_q[7:0], 8'h00, bmask_q[15:8], 8'h00};
	assign st_clr = {rd_dst, rd_dext, rd_bst[0], rd_bext[0], rd_bst[1], rd_bext[1]};

	generate
		for (g = 0; g < 6; g = g + 1) begin : g_st
			isd_sticky #(
				.W(8)
			) u_st (
				.clk(clk),
				.reset(reset),
				.set(st_set[8*g+7:8*g]),
				.mask(st_mask[8*g+7:8*g]),
				.rd_clr(st_clr[g]),
				.view(st_view[8*g+7:8*g]),
				.pend(st_pend[g])
			);
		end
	endgenerate

	// Summary bits follow sub-register contents directly
	assign top = {aux_q, st_pend};

	// Read mux; unmapped addresses read zero
	always @* begin
		rd_d = `ISD_REG_RST;
		if (glob) begin
			case (addr)
				`ISD_A_TOP: rd_d = top;
				`ISD_A_TMASK: rd_d = tmask_q;
				`ISD_A_AUXCFG: rd_d = auxcfg_q;
				`ISD_A_DST: rd_d = st_view[47:40];
				`ISD_A_DMASK: rd_d = dmask_q;
				`ISD_A_DEXT: rd_d = st_view[39:32];
				default: rd_d = `ISD_REG_RST;
			endcase
		end else if (ch_a) begin
			case (off)
				`ISD_O_ST: rd_d = st_view[31:24];
				`ISD_O_MASK: rd_d = bmask_q[7:0];
				`ISD_O_EXT: rd_d = st_view[23:16];
				`ISD_O_CMD2: rd_d = {7'h00, rie_q[0]};
				`ISD_O_HDR: rd_d = hdr[7:0];
				`ISD_O_ADDR: rd_d = adl[7:0];
				`ISD_O_RSTAT: rd_d = {4'h0, rst4[3:0]};
				default: rd_d = `ISD_REG_RST;
			endcase
		end else if (ch_b) begin
			case (off)
				`ISD_O_ST: rd_d = st_view[15:8];
				`ISD_O_MASK: rd_d = bmask_q[15:8];
				`ISD_O_EXT: rd_d = st_view[7:0];
				`ISD_O_CMD2: rd_d = {7'h00, rie_q[1]};
				`ISD_O_HDR: rd_d = hdr[15:8];
				`ISD_O_ADDR: rd_d = adl[15:8];
				`ISD_O_RSTAT: rd_d = {4'h0, rst4[7:4]};
				default: rd_d = `ISD_REG_RST;
			endcase
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			rdata_q <= `ISD_REG_RST;
			int_n_q <= 1'b1;
		end else begin
			// Data stand only in the cycle after the read strobe
			rdata_q <= rd ? rd_d : `ISD_REG_RST;
			// Level request: stays low while anything unmasked remains, so a host may need a fresh edge
			int_n_q <= ~|(top & ~tmask_q);
		end
	end
endmodule // isd_irq_agg

/* File: test/isd_irq_agg_sva.sv */
// Checker for the interrupt aggregator: request line and register read relations.
// Assumes binding to isd_irq_agg; host writes are shadowed from the port.
`timescale 1ns/1ps
module isd_irq_agg_chk (
	input wire clk,
	input wire reset,
	input wire [4:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata_q,
	input wire int_n_q,
	input wire aux_in_six_n,
	input wire [7:0] dchan_ext_evt
);
	reg [7:0] tmask_q;
	reg [7:0] amask_q;
	reg level6_q;
	reg [3:0] low6_q;
	always @(posedge clk) begin
		if (reset) begin
			tmask_q <= 8'h00;
			amask_q <= 8'h00;
			level6_q <= 1'b1;
			low6_q <= 4'h0;
		end else begin
			if (wr && addr == 5'h01)
				tmask_q <= wdata;
			if (wr && addr == 5'h09)
				amask_q <= wdata;
			if (wr && addr == 5'h02)
				level6_q <= !wdata[0];
			// Saturates: only long enough low matters
			low6_q <= aux_in_six_n ? 4'h0 : (low6_q == 4'h8 ? 4'h8 : low6_q + 4'h1);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_int_on_event;
		(dchan_ext_evt != 8'h00 && !tmask_q[4] && !wr) |-> ##2 !int_n_q;
	endproperty
	a_int_on_event: assert property (p_int_on_event) else $error("request missed");
	property p_int_holds;
		(!int_n_q && !$past(rd) && !$past(wr)) |=> !int_n_q;
	endproperty
	a_int_holds: assert property (p_int_holds) else $error("request dropped early");
	property p_mask_all;
		(tmask_q == 8'hff && $past(tmask_q) == 8'hff) |-> int_n_q;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("request under full mask");
	property p_top_ptr;
		(dchan_ext_evt != 8'h00) ##1 !rd ##1 (rd && addr == 5'h00) |=> rdata_q[4];
	endproperty
	a_top_ptr: assert property (p_top_ptr) else $error("pointer bit missing");
	property p_dext_clear;
		(rd && addr == 5'h05 && dchan_ext_evt == 8'h00) ##1 (!rd && dchan_ext_evt == 8'h00) [*2]
			##1 (rd && addr == 5'h05) |=> rdata_q == 8'h00;
	endproperty
	a_dext_clear: assert property (p_dext_clear) else $error("extended not cleared");
	property p_bmask_hide;
		(rd && addr == 5'h08 && amask_q == 8'hff) |=> rdata_q == 8'h00;
	endproperty
	a_bmask_hide: assert property (p_bmask_hide) else $error("masked bit shown");
	property p_aux_level;
		(rd && addr == 5'h00 && level6_q && low6_q == 4'h8) |=> rdata_q[6];
	endproperty
	a_aux_level: assert property (p_aux_level) else $error("aux level lost");
	property p_rdata_only;
		(rdata_q != 8'h00) |-> $past(rd);
	endproperty
	a_rdata_only: assert property (p_rdata_only) else $error("stray read data");
endmodule // isd_irq_agg_chk

/* File: test/isd_host_model.sv */
// Host processor model: register port master and service routine steps.
// Assumes the plain register port of isd_irq_agg on the shared clock.
`timescale 1ns/1ps
module isd_host_model (
	input wire clk,
	input wire [7:0] rdata_q,
	output logic [4:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	localparam logic [29:0] SUB = {5'h03, 5'h05, 5'h08, 5'h0a, 5'h10, 5'h12};
	initial begin
		addr = 5'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task wr_reg(input [4:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input [4:0] a, output [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		// Data settle after the edge that takes the strobe; gone at the next one
		#1 d = rdata_q;
		@(posedge clk);
	endtask
	// Top status first, then only the sub-registers it points at
	task service(output [7:0] top);
		logic [7:0] v;
		rd_reg(5'h00, top);
		for (int i = 0; i < 6; i++)
			if (top[i])
				rd_reg(SUB[5*i +: 5], v);
	endtask
	// Full mask held four cycles so an edge-sensitive host sees a fresh edge
	task refresh(input [7:0] old);
		wr_reg(5'h01, 8'hff);
		repeat (2) @(posedge clk);
		wr_reg(5'h01, old);
	endtask
endmodule // isd_host_model

/* File: test/test_isd_irq_agg.sv */
// Testbench for the interrupt aggregator: one task per scenario.
// Assumes the host model drives the register port; checker bound at the foot.
`timescale 1ns/1ps
module test_isd_irq_agg;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic a6 = 1'b1, a7 = 1'b1;
	logic [7:0] dse = 8'h00, dxe = 8'h00, rs = 8'h96;
	logic [11:0] bse = 12'h000;
	logic [1:0] bs = 2'h0, fo = 2'h0, ao = 2'h0, md = 2'h0, ff = 2'h0, tr = 2'h0;
	logic [15:0] hd = 16'h5aa5, ad = 16'h3cc3;
	wire [4:0] addr;
	wire [7:0] wdata, rdata_q;
	wire wr, rd, int_n_q;
	integer fails = 0, cmp_count = 0;
	always #5 clk = ~clk;
	isd_host_model host (.clk(clk), .rdata_q(rdata_q), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	isd_irq_agg #(.POOL(64), .DLY(2)) DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_q(rdata_q), .int_n_q(int_n_q), .aux_in_six_n(a6), .aux_in_seven_n(a7),
		.dchan_status_evt(dse), .dchan_ext_evt(dxe), .rx_byte_stored(bs), .rx_frame_open(fo),
		.rx_addr_ok(ao), .rx_msg_done(md), .rx_fifo_full(ff), .rx_transparent(tr), .rx_hdr_in(hd),
		.rx_addr_in(ad), .rx_rstat_in(rs), .bchan_status_evt(bse), .bchan_ext_evt(12'h000));
	task chk(input [7:0] got, input [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rc(input [4:0] a, input [7:0] e);
		logic [7:0] v;
		host.rd_reg(a, v);
		chk(v, e);
	endtask
	task ic(input e);
		// Look after the edge has settled the registered request
		#1 chk({7'h00, int_n_q}, {7'h00, e});
	endtask
	task bytes(input [1:0] m, input integer n);
		@(posedge clk) bs <= m;
		repeat (n) @(posedge clk);
		bs <= 2'h0;
	endtask
	task frame(input [1:0] m, input integer n, input logic d);
		@(posedge clk) fo <= m;
		@(posedge clk) fo <= 2'h0;
		ao <= m;
		@(posedge clk) ao <= 2'h0;
		bytes(m, n);
		@(posedge clk) md <= d ? m : 2'h0;
		@(posedge clk) md <= 2'h0;
	endtask
	task t_reset;
		host.wr_reg(5'h1f, 8'hff);
		for (int a = 0; a < 32; a++)
			rc(a[4:0], 8'h00);
		ic(1'b1);
		$display("reset values done");
	endtask
	task t_dchan;
		logic [7:0] t;
		@(posedge clk) dse <= 8'h01;
		@(posedge clk) dse <= 8'h00;
		repeat (2) @(posedge clk);
		ic(1'b0);
		host.service(t);
		chk(t, 8'h20);
		repeat (2) @(posedge clk);
		ic(1'b1);
		@(posedge clk) dxe <= 8'h08;
		@(posedge clk) dxe <= 8'h00;
		host.service(t);
		chk(t, 8'h10);
		rc(5'h05, 8'h00);
		rc(5'h00, 8'h00);
		$display("d channel done");
	endtask
	task t_mask;
		host.wr_reg(5'h01, 8'h20);
		@(posedge clk) dse <= 8'h02;
		@(posedge clk) dse <= 8'h00;
		repeat (3) @(posedge clk);
		ic(1'b1);
		rc(5'h00, 8'h20);
		host.refresh(8'h00);
		repeat (2) @(posedge clk);
		ic(1'b0);
		rc(5'h03, 8'h02);
		repeat (2) @(posedge clk);
		ic(1'b1);
		host.wr_reg(5'h09, 8'hff);
		@(posedge clk) bse <= 12'h001;
		@(posedge clk) bse <= 12'h000;
		rc(5'h08, 8'h00);
		rc(5'h00, 8'h00);
		ic(1'b1);
		host.wr_reg(5'h09, 8'h00);
		rc(5'h00, 8'h08);
		rc(5'h08, 8'h01);
		rc(5'h08, 8'h00);
		$display("masks done");
	endtask
	task t_rx;
		logic [4:0] b;
		logic [1:0] m;
		for (int c = 0; c < 2; c++) begin
			b = c ? 5'h10 : 5'h08;
			m = c ? 2'h2 : 2'h1;
			tr <= c ? 2'h0 : 2'h1;
			host.wr_reg(b + 5'h03, 8'h01);
			frame(m, 1, 1'b0);
			rc(b + 5'h02, 8'h00);
			bytes(m, 1);
			rc(b + 5'h02, 8'h40);
			rc(b + 5'h04, hd[8*c +: 8]);
			rc(b + 5'h05, ad[8*c +: 8]);
			rc(b + 5'h06, {4'h0, rs[4*c +: 4]});
			bytes(m, 62);
			rc(b, 8'h40);
			@(posedge clk) md <= m;
			@(posedge clk) md <= 2'h0;
			rc(b, 8'h80);
			host.wr_reg(b + 5'h03, 8'h00);
			frame(m, 2, 1'b1);
			rc(b + 5'h02, 8'h00);
			rc(b, 8'h80);
			ff <= m;
			@(posedge clk) fo <= m;
			@(posedge clk) fo <= 2'h0;
			ff <= 2'h0;
			rc(b + 5'h02, 8'h80);
		end
		$display("receive events done");
	endtask
	task t_aux;
		host.wr_reg(5'h02, 8'h02);
		a6 <= 1'b0;
		repeat (10) @(posedge clk);
		rc(5'h00, 8'h40);
		ic(1'b0);
		host.wr_reg(5'h00, 8'h40);
		rc(5'h00, 8'h40);
		a6 <= 1'b1;
		a7 <= 1'b0;
		repeat (10) @(posedge clk);
		host.wr_reg(5'h00, 8'h40);
		rc(5'h00, 8'h80);
		host.wr_reg(5'h00, 8'h80);
		rc(5'h00, 8'h00);
		a7 <= 1'b1;
		$display("aux pins done");
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_dchan;
		t_mask;
		t_rx;
		t_aux;
		end_of_test;
	end
	// Whole run is a few hundred cycles
	initial begin
		#200000;
		fails++;
		end_of_test;
	end
endmodule // test_isd_irq_agg
bind isd_irq_agg isd_irq_agg_chk u_chk (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata_q(rdata_q), .int_n_q(int_n_q), .aux_in_six_n(aux_in_six_n), .dchan_ext_evt(dchan_ext_evt));
